// file: hdl/sxd_cfg.svh
// Constants for the stretched external data access unit.
// Assumes inclusion by bare name from the design files.
`ifndef SXD_CFG_SVH
`define SXD_CFG_SVH
`define SXD_CLK_PER_MC      3'h4
`define SXD_ADDR_DPL0       8'h82
`define SXD_ADDR_DPH0       8'h83
`define SXD_ADDR_DATA_POINTER1_LOW       8'h84
`define SXD_ADDR_DATA_POINTER1_HIGH       8'h85
`define SXD_ADDR_PSEL       8'h86
`define SXD_ADDR_CLOCK_AND_STRETCH_CONTROL      8'h8E
`define SXD_STRETCH_MSB     2
`define SXD_STRETCH_LSB     0
`define SXD_CLOCK_AND_STRETCH_CONTROL_RESET     8'h01
`define SXD_PSEL_RESET      1'h0
`define SXD_PTR_RESET       16'h0000
`endif

// file: hdl/sxd_pkg.sv
// Types for the stretched external data access unit.
// Assumes nothing beyond a SystemVerilog compiler.
package sxd_pkg;
    typedef enum logic [2:0] {
        SXD_IDLE  = 3'h0,
        SXD_ADDR  = 3'h1,
        SXD_STRB  = 3'h2,
        SXD_HOLD  = 3'h3,
        SXD_DONE  = 3'h4
    } sxd_state_e;
    typedef logic [7:0] sxd_byte_t;
endpackage

// file: hdl/sxd_ptr_bank.sv
// Two 16-bit data pointers with registered read data.
// Assumes writes and increments are mutually exclusive per cycle from the core.
`timescale 1ns/1ps
`default_nettype none
`include "sxd_cfg.svh"
module sxd_ptr_bank (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        wr_en_i,
    input  wire logic        wr_sel_i,
    input  wire logic        wr_hi_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        inc_i,
    input  wire logic        ld16_i,
    input  wire logic [15:0] ld16_data_i,
    input  wire logic        act_sel_i,
    output logic      [15:0] ptr0_o,
    output logic      [15:0] ptr1_o
);
    logic [15:0] ptr_ff [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ptr
            always_ff @(posedge mclk_i) begin
                if (reset_i) begin
                    ptr_ff[g] <= `SXD_PTR_RESET;
                end else if (wr_en_i && (wr_sel_i == 1'(g))) begin
                    if (wr_hi_i) begin
                        ptr_ff[g][15:8] <= wr_data_i;
                    end else begin
                        ptr_ff[g][7:0] <= wr_data_i;
                    end
                end else if (ld16_i && (act_sel_i == 1'(g))) begin
                    ptr_ff[g] <= ld16_data_i;
                end else if (inc_i && (act_sel_i == 1'(g))) begin
                    ptr_ff[g] <= ptr_ff[g] + 16'h0001;
                end
            end
        end
    endgenerate
    assign ptr0_o = ptr_ff[0];
    assign ptr1_o = ptr_ff[1];
endmodule // sxd_ptr_bank
`default_nettype wire

// file: hdl/sxd_top.sv
// External data access sequencer with stretch control and dual data pointers.
// Assumes the core presents SFR accesses and access requests synchronous to mclk_i.
// What this block does
// - A machine cycle is four clocks; move lengths count machine cycles, strobe widths count clocks.
// - Low address and data share the low port; the upper address goes on the high port.
// - Code fetches run at fixed speed; only external data moves are stretched.
// - Stretch 0..7 gives external data moves of 2..9 machine cycles.
// - Stretch resets to 1, giving three-cycle data moves.
// - Stretch sits in bits 2..0 of the clock control register at 8Eh.
// - Strobe width is 2 clocks at code 0, else 4 clocks per code, up to 28.
// - A new stretch value applies to every later data move.
// - First pointer at 82h/83h, second at 84h/85h.
// - Only bit 0 of the select register at 86h exists; others read zero.
// - Pointer instructions act on the currently selected pointer.
// - Incrementing the select register toggles the active pointer.
// - Reset clears the select bit so the first pointer is active.
// - One address latch pulse is issued every machine cycle.
`timescale 1ns/1ps
`default_nettype none
`include "sxd_cfg.svh"
module sxd_top (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    output logic             sfr_hit_o,
    input  wire logic        psel_inc_i,
    input  wire logic        ptr_inc_i,
    input  wire logic        ptr_ld_i,
    input  wire logic [15:0] ptr_ld_data_i,
    input  wire logic        xmove_req_i,
    input  wire logic        xmove_wr_i,
    input  wire logic        xmove_use_ptr_i,
    input  wire logic [7:0]  xmove_ri_addr_i,
    input  wire logic [7:0]  xmove_wdata_i,
    output logic             xmove_busy_o,
    output logic             xmove_done_o,
    output logic      [7:0]  xmove_rdata_o,
    output logic      [15:0] active_ptr_o,
    output logic             ale_o,
    output logic             rd_n_o,
    output logic             wr_n_o,
    output logic      [7:0]  low_port_o,
    output logic             low_port_oe_o,
    input  wire logic [7:0]  low_port_i,
    output logic      [7:0]  high_port_o
);
    sxd_pkg::sxd_state_e state_ff, nxt_state;
    logic [1:0]  phase_ff;
    logic        mc_end;
    logic [7:0]  clock_and_stretch_control_ff;
    logic        psel_ff;
    logic [15:0] ptr0, ptr1;
    logic [2:0]  stretch_ff;
    logic        wr_ff;
    logic [15:0] addr_ff;
    logic [7:0]  wdata_ff;
    logic [4:0]  strb_cnt_ff;
    logic [4:0]  strb_len;
    logic [3:0]  mc_cnt_ff;
    logic [7:0]  rdata_ff;
    logic [7:0]  sfr_rdata_ff;
    logic        ale_ff;
    logic        ptr_wr;

    // Free running machine cycle phase; every stall is a whole cycle count
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end
    assign mc_end = (phase_ff == 2'(`SXD_CLK_PER_MC - 3'h1));

    // Address latch once per machine cycle, first clock of it
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            ale_ff <= 1'b0;
        end else begin
            ale_ff <= mc_end;
        end
    end
    assign ale_o = ale_ff;

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            clock_and_stretch_control_ff <= `SXD_CLOCK_AND_STRETCH_CONTROL_RESET;
        end else if (sfr_wr_i && sfr_addr_i == `SXD_ADDR_CLOCK_AND_STRETCH_CONTROL) begin
            clock_and_stretch_control_ff <= sfr_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            psel_ff <= `SXD_PSEL_RESET;
        end else if (sfr_wr_i && sfr_addr_i == `SXD_ADDR_PSEL) begin
            psel_ff <= sfr_wdata_i[0];
        end else if (psel_inc_i) begin
            psel_ff <= ~psel_ff;
        end
    end

    // Only the four pointer bytes; the select register and its neighbours must not alias in
    assign ptr_wr = sfr_wr_i && (sfr_addr_i == `SXD_ADDR_DPL0 || sfr_addr_i == `SXD_ADDR_DPH0 ||
                                 sfr_addr_i == `SXD_ADDR_DATA_POINTER1_LOW || sfr_addr_i == `SXD_ADDR_DATA_POINTER1_HIGH);
    sxd_ptr_bank u_ptr (
        .mclk_i      (mclk_i),
        .reset_i     (reset_i),
        .wr_en_i     (ptr_wr),
        .wr_sel_i    (sfr_addr_i == `SXD_ADDR_DATA_POINTER1_LOW || sfr_addr_i == `SXD_ADDR_DATA_POINTER1_HIGH),
        .wr_hi_i     (sfr_addr_i == `SXD_ADDR_DPH0 || sfr_addr_i == `SXD_ADDR_DATA_POINTER1_HIGH),
        .wr_data_i   (sfr_wdata_i),
        .inc_i       (ptr_inc_i),
        .ld16_i      (ptr_ld_i),
        .ld16_data_i (ptr_ld_data_i),
        .act_sel_i   (psel_ff),
        .ptr0_o      (ptr0),
        .ptr1_o      (ptr1)
    );
    assign active_ptr_o = psel_ff ? ptr1 : ptr0;

    always_comb begin
        sfr_hit_o = 1'b1;
        unique case (sfr_addr_i)
            `SXD_ADDR_DPL0:  sfr_rdata_o = ptr0[7:0];
            `SXD_ADDR_DPH0:  sfr_rdata_o = ptr0[15:8];
            `SXD_ADDR_DATA_POINTER1_LOW:  sfr_rdata_o = ptr1[7:0];
            `SXD_ADDR_DATA_POINTER1_HIGH:  sfr_rdata_o = ptr1[15:8];
            `SXD_ADDR_PSEL:  sfr_rdata_o = {7'h00, psel_ff};
            `SXD_ADDR_CLOCK_AND_STRETCH_CONTROL: sfr_rdata_o = clock_and_stretch_control_ff;
            default: begin
                sfr_rdata_o = 8'h00;
                sfr_hit_o   = 1'b0;
            end
        endcase
    end

    // Stretch 0 strobes 2 clocks, code n strobes 4n clocks
    assign strb_len = (stretch_ff == 3'h0) ? 5'h02 : {stretch_ff, 2'h0};

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            sxd_pkg::SXD_IDLE: if (xmove_req_i && mc_end) nxt_state = sxd_pkg::SXD_ADDR;
            sxd_pkg::SXD_ADDR: if (phase_ff == 2'h1) nxt_state = sxd_pkg::SXD_STRB;
            sxd_pkg::SXD_STRB: if (strb_cnt_ff == strb_len - 5'h01) nxt_state = sxd_pkg::SXD_HOLD;
            sxd_pkg::SXD_HOLD: if (mc_end && mc_cnt_ff == {1'b0, stretch_ff} + 4'h1)
                nxt_state = sxd_pkg::SXD_DONE;
            sxd_pkg::SXD_DONE: nxt_state = sxd_pkg::SXD_IDLE;
            default: nxt_state = sxd_pkg::SXD_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_ff <= sxd_pkg::SXD_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Access parameters latched at launch; stretch sampled fresh every access
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            stretch_ff <= 3'h1;
            wr_ff      <= 1'b0;
            addr_ff    <= 16'h0000;
            wdata_ff   <= 8'h00;
        end else if (state_ff == sxd_pkg::SXD_IDLE && nxt_state == sxd_pkg::SXD_ADDR) begin
            stretch_ff <= clock_and_stretch_control_ff[`SXD_STRETCH_MSB:`SXD_STRETCH_LSB];
            wr_ff      <= xmove_wr_i;
            addr_ff    <= xmove_use_ptr_i ? active_ptr_o : {high_port_o, xmove_ri_addr_i};
            wdata_ff   <= xmove_wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            strb_cnt_ff <= 5'h00;
        end else if (state_ff == sxd_pkg::SXD_STRB) begin
            strb_cnt_ff <= strb_cnt_ff + 5'h01;
        end else begin
            strb_cnt_ff <= 5'h00;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mc_cnt_ff <= 4'h0;
        end else if (state_ff == sxd_pkg::SXD_IDLE) begin
            mc_cnt_ff <= 4'h0;
        end else if (mc_end) begin
            mc_cnt_ff <= mc_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_ff <= 8'h00;
        end else if (state_ff == sxd_pkg::SXD_STRB && !wr_ff &&
                     strb_cnt_ff == strb_len - 5'h01) begin
            rdata_ff <= low_port_i;
        end
    end

    // High byte taken from the active pointer at launch of a pointer move, valid under the first latch pulse; it then
    // holds between accesses so an idle bus does not glitch
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            high_port_o <= 8'h00;
        end else if (state_ff == sxd_pkg::SXD_IDLE && nxt_state == sxd_pkg::SXD_ADDR) begin
            high_port_o <= xmove_use_ptr_i ? active_ptr_o[15:8] : high_port_o;
        end
    end

    always_comb begin
        low_port_o    = 8'h00;
        low_port_oe_o = 1'b0;
        if (state_ff == sxd_pkg::SXD_ADDR) begin
            low_port_o    = addr_ff[7:0];
            low_port_oe_o = 1'b1;
        end else if (state_ff == sxd_pkg::SXD_STRB && wr_ff) begin
            low_port_o    = wdata_ff;
            low_port_oe_o = 1'b1;
        end
    end

    assign rd_n_o        = !(state_ff == sxd_pkg::SXD_STRB && !wr_ff);
    assign wr_n_o        = !(state_ff == sxd_pkg::SXD_STRB && wr_ff);
    assign xmove_busy_o  = (state_ff != sxd_pkg::SXD_IDLE);
    assign xmove_done_o  = (state_ff == sxd_pkg::SXD_DONE);
    assign xmove_rdata_o = rdata_ff;

    a_ale_period: assert property (@(posedge mclk_i) disable iff (reset_i)
        ale_o |=> !ale_o [*3] ##1 ale_o) else $error("ALE not once per machine cycle");
    a_psel_toggle: assert property (@(posedge mclk_i) disable iff (reset_i)
        psel_inc_i && !sfr_wr_i |=> psel_ff != $past(psel_ff))
        else $error("Select did not toggle");
    a_psel_read: assert property (@(posedge mclk_i) disable iff (reset_i)
        sfr_addr_i == 8'h86 |-> sfr_rdata_o[7:1] == 7'h00)
        else $error("Select upper bits nonzero");
    a_strobe_len: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(rd_n_o && wr_n_o) && stretch_ff == 3'h0 |-> !(rd_n_o && wr_n_o) [*2] ##1
        (rd_n_o && wr_n_o)) else $error("Stretch 0 strobe not 2 clocks");
    a_strobe_long: assert property (@(posedge mclk_i) disable iff (reset_i)
        $fell(rd_n_o && wr_n_o) && stretch_ff == 3'h2 |-> !(rd_n_o && wr_n_o) [*8] ##1
        (rd_n_o && wr_n_o)) else $error("Stretch 2 strobe not 8 clocks");
    a_high_stable: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_ff == sxd_pkg::SXD_STRB |-> $stable(high_port_o))
        else $error("High address moved in strobe");
    a_strobe_noaddr: assert property (@(posedge mclk_i) disable iff (reset_i)
        state_ff == sxd_pkg::SXD_ADDR |-> rd_n_o && wr_n_o)
        else $error("Strobe overlaps address phase");
    a_move_len0: assert property (@(posedge mclk_i) disable iff (reset_i)
        $rose(xmove_busy_o) && stretch_ff == 3'h0 |-> xmove_busy_o [*8]
        ##1 xmove_done_o) else $error("Stretch 0 move not 2 machine cycles");
    a_reset_stretch: assert property (@(posedge mclk_i)
        $past(reset_i) |-> clock_and_stretch_control_ff == 8'h01 && !psel_ff)
        else $error("Reset values wrong");
endmodule // sxd_top
`default_nettype wire

// file: dv/sxd_sram_model.sv
// External SRAM model on the multiplexed low port and the high address port.
// Assumes active-low strobes and an address phase marked by ale with the port driven.
`timescale 1ns/1ps
`default_nettype none
module sxd_sram_model (
    input  wire logic       mclk_i,
    input  wire logic       ale_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic       oe_i,
    input  wire logic [7:0] lo_i,
    input  wire logic [7:0] hi_i,
    input  wire logic [2:0] lat_i,
    output logic      [7:0] bus_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr;
    logic [7:0]  last = 8'h00;
    logic [2:0]  cnt  = 3'h0;
    always @(posedge mclk_i) begin
        // Address is frozen while a strobe is low
        if (ale_i === 1'b1 && rd_n_i && wr_n_i && oe_i) begin
            addr <= {hi_i, lo_i};
        end
        if (rd_n_i && wr_n_i) begin
            cnt <= 3'h0;
        end else if (cnt != 3'h7) begin
            cnt <= cnt + 3'h1;
        end
        if (wr_n_i === 1'b0) begin
            mem[addr] <= lo_i;
        end
        last <= bus_o;
    end
    // No pull-up: a released or not-yet-ready bus shows a toggling pattern
    always_comb begin
        if (oe_i) begin
            bus_o = lo_i;
        end else if (rd_n_i === 1'b0 && cnt >= lat_i) begin
            bus_o = mem[addr];
        end else begin
            bus_o = ~last;
        end
    end
endmodule // sxd_sram_model
`default_nettype wire

// file: dv/stretched_xdata_access_dual_pointer_tb.sv
// Self-checking bench for the stretched external data access unit.
// Assumes the SRAM model on the far side and a 20 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
module stretched_xdata_access_dual_pointer_tb;
    logic        mclk_i, reset_i, sfr_wr_i, sfr_rd_i, psel_inc_i, ptr_inc_i, ptr_ld_i;
    logic        xmove_req_i, xmove_wr_i, xmove_use_ptr_i, sfr_hit_o, xmove_busy_o;
    logic        xmove_done_o, ale_o, rd_n_o, wr_n_o, low_port_oe_o;
    logic [7:0]  sfr_addr_i, sfr_wdata_i, xmove_ri_addr_i, xmove_wdata_i, bus;
    logic [7:0]  sfr_rdata_o, xmove_rdata_o, low_port_o, high_port_o;
    logic [15:0] ptr_ld_data_i, active_ptr_o;
    logic [2:0]  lat;
    int          n_mismatch = 0, tests_run = 0, ale_gap = 0, s;

    sxd_top dut (.mclk_i, .reset_i, .sfr_wr_i, .sfr_rd_i, .sfr_addr_i, .sfr_wdata_i,
        .sfr_rdata_o, .sfr_hit_o, .psel_inc_i, .ptr_inc_i, .ptr_ld_i, .ptr_ld_data_i,
        .xmove_req_i, .xmove_wr_i, .xmove_use_ptr_i, .xmove_ri_addr_i, .xmove_wdata_i,
        .xmove_busy_o, .xmove_done_o, .xmove_rdata_o, .active_ptr_o, .ale_o, .rd_n_o,
        .wr_n_o, .low_port_o, .low_port_oe_o, .low_port_i(bus), .high_port_o);
    sxd_sram_model mdl (.mclk_i, .ale_i(ale_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
        .oe_i(low_port_oe_o), .lo_i(low_port_o), .hi_i(high_port_o), .lat_i(lat), .bus_o(bus));

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic summarize;
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic sfr_w(input logic [7:0] a, d);
        @(negedge mclk_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'b1;
        @(negedge mclk_i);
        sfr_wr_i = 1'b0;
    endtask

    task automatic sfr_chk(input logic [7:0] a, e, input logic h);
        @(negedge mclk_i);
        sfr_addr_i = a;
        sfr_rd_i = 1'b1;
        #5;
        chk("sfr_rdata", {8'h00, e}, {8'h00, sfr_rdata_o});
        chk("sfr_hit", {15'h0, h}, {15'h0, sfr_hit_o});
        sfr_rd_i = 1'b0;
    endtask

    // Holds the request until busy shows it was taken, then counts busy and strobe clocks
    task automatic xmove(input logic wr, up, input logic [7:0] ri, wd, input int st);
        int i, nb, ns;
        i = 0;
        nb = 0;
        ns = 0;
        @(negedge mclk_i);
        {xmove_wr_i, xmove_use_ptr_i, xmove_ri_addr_i, xmove_wdata_i} = {wr, up, ri, wd};
        xmove_req_i = 1'b1;
        while (xmove_busy_o !== 1'b1 && i < 8) begin
            @(negedge mclk_i);
            i++;
        end
        xmove_req_i = 1'b0;
        // Busy also covers the done cycle; stop there so done is seen while it stands
        while (xmove_busy_o === 1'b1 && xmove_done_o !== 1'b1 && nb < 100) begin
            nb++;
            if (rd_n_o === 1'b0 || wr_n_o === 1'b0) ns++;
            @(negedge mclk_i);
        end
        chk("busy_clocks", 16'(4 * (st + 2)), 16'(nb));
        chk("strobe_clocks", 16'((st == 0) ? 2 : 4 * st), 16'(ns));
        chk("done", 16'h0001, {15'h0, xmove_done_o});
        @(negedge mclk_i);
    endtask

    always @(negedge mclk_i) begin
        if (reset_i) begin
            ale_gap = 0;
        end else if (ale_o === 1'b1) begin
            if (ale_gap != 0) chk("ale_gap", 16'h0004, 16'(ale_gap));
            ale_gap = 1;
        end else if (ale_gap != 0) begin
            ale_gap++;
        end
    end

    initial begin
        #(50 * 20000);
        n_mismatch++;
        summarize();
    end

    initial begin
        {sfr_wr_i, sfr_rd_i, psel_inc_i, ptr_inc_i, ptr_ld_i} = 5'h00;
        {xmove_req_i, xmove_wr_i, xmove_use_ptr_i} = 3'h0;
        {sfr_addr_i, sfr_wdata_i, xmove_ri_addr_i, xmove_wdata_i} = 32'h0;
        ptr_ld_data_i = 16'h0000;
        lat = 3'h0;
        reset_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        reset_i = 1'b0;
        sfr_chk(8'h8E, 8'h01, 1'b1);
        sfr_chk(8'h86, 8'h00, 1'b1);
        sfr_chk(8'h80, 8'h00, 1'b0);
        for (s = 0; s < 4; s++) sfr_w(8'(8'h82 + s), 8'(8'h11 * (s + 1)));
        for (s = 0; s < 4; s++) sfr_chk(8'(8'h82 + s), 8'(8'h11 * (s + 1)), 1'b1);
        chk("active_ptr", 16'h2211, active_ptr_o);
        @(negedge mclk_i);
        psel_inc_i = 1'b1;
        @(negedge mclk_i);
        psel_inc_i = 1'b0;
        sfr_chk(8'h86, 8'h01, 1'b1);
        chk("active_ptr", 16'h4433, active_ptr_o);
        sfr_w(8'h86, 8'hFF);
        sfr_chk(8'h86, 8'h01, 1'b1);
        @(negedge mclk_i);
        ptr_ld_data_i = 16'hABFF;
        ptr_ld_i = 1'b1;
        @(negedge mclk_i);
        ptr_ld_i = 1'b0;
        ptr_inc_i = 1'b1;
        @(negedge mclk_i);
        ptr_inc_i = 1'b0;
        chk("active_ptr", 16'hAC00, active_ptr_o);
        sfr_chk(8'h82, 8'h11, 1'b1);
        sfr_w(8'h86, 8'hFE);
        sfr_chk(8'h86, 8'h00, 1'b1);
        for (s = 0; s < 8; s++) begin
            sfr_w(8'h8E, 8'(s));
            sfr_chk(8'h8E, 8'(s), 1'b1);
            sfr_w(8'h82, 8'(8'h10 + s));
            sfr_w(8'h83, 8'(8'h40 + s));
            xmove(1'b1, 1'b1, 8'h00, 8'(8'hC0 + s), s);
            chk("high_port", 16'(8'h40 + s), {8'h00, high_port_o});
            chk("sram", 16'(8'hC0 + s), {8'h00, mdl.mem[{8'(8'h40 + s), 8'(8'h10 + s)}]});
            xmove(1'b0, 1'b0, 8'(8'h10 + s), 8'h00, s);
            chk("rdata", 16'(8'hC0 + s), {8'h00, xmove_rdata_o});
        end
        // Slow peripheral: too short a strobe must miss the data, a longer one must not
        lat = 3'h3;
        sfr_w(8'h8E, 8'h00);
        xmove(1'b0, 1'b1, 8'h00, 8'h00, 0);
        chk("slow_miss", 16'h0001, {15'h0, xmove_rdata_o !== 8'hC7});
        sfr_w(8'h8E, 8'h01);
        xmove(1'b0, 1'b1, 8'h00, 8'h00, 1);
        chk("rdata", 16'h00C7, {8'h00, xmove_rdata_o});
        // External move through the second pointer, which holds AC00h from the load of ABFFh and the increment
        sfr_w(8'h86, 8'h01);
        xmove(1'b1, 1'b1, 8'h00, 8'h5A, 1);
        chk("high_port", 16'h00AC, {8'h00, high_port_o});
        chk("sram_ptr1", 16'h005A, {8'h00, mdl.mem[16'hAC00]});
        summarize();
    end
endmodule // stretched_xdata_access_dual_pointer_tb
`default_nettype wire
